// ==== rtl/dma_map.svh ====
// register offsets, field positions, reset values of the repeat-area dma channel
// How it works
// - 16-bit block count, one means one block
// - zero count: counting halted, no end interrupt
// - all-ones count gives 65,535 blocks
// - count reads remaining blocks, decrements per block
// - independent 5-bit source and destination sizes
// - source overflow with enable: flag, stop
// - overflow stop with irq enable requests interrupt
// - destination overflow with enable: flag, stop
// - writing active resumes from current state
// - 8-bit block size, zero means 256
`ifndef DMA_MAP_SVH
`define DMA_MAP_SVH

`define OFF_SRC_ADDR 8'h00
`define OFF_DST_ADDR 8'h04
`define OFF_COUNT 8'h08
`define OFF_MODE 8'h0c
`define OFF_ADDR_CTRL 8'h10
`define OFF_STATUS 8'h14
`define OFF_INT_EN 8'h18
`define OFF_INT_CLR 8'h1c

`define COUNT_BLKSZ_LSB 16
`define MODE_ACTIVE 0
`define MODE_IRQ_EN 1
`define MODE_FLAG 2
`define MODE_WORD 3
`define ACTRL_SRC_LSB 0
`define ACTRL_DST_LSB 8
`define ACTRL_SRC_IE 16
`define ACTRL_DST_IE 17
`define EV_SRC_OVF 0
`define EV_DST_OVF 1
`define EV_END 2

`define RST_ADDR 32'h0000_0000
`define RST_COUNT 16'h0000
`define RST_BLKSZ 8'h00
`define RST_SIZE 5'h00

`endif

// ==== rtl/dma_pkg.sv ====
// types shared by the repeat-area dma channel
package dma_pkg;
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_RUN = 2'b01,
        CH_HALT = 2'b10
    } chanState_t;
endpackage

// ==== rtl/repeat_area_addr.sv ====
// next address of one pointer inside its power-of-two repeat area
`timescale 1ns/1ps
module repeat_area_addr (
    input wire logic [31:0] addr,
    input wire logic [4:0] size,
    input wire logic [1:0] step,
    output logic [31:0] nextAddr,
    output logic overflow
);
    logic [31:0] mask;
    logic [32:0] low;

    always_comb begin
        // size zero means no repeat area: plain increment
        mask = (size == 5'h00) ? 32'h0 : ((32'h1 << size) - 32'h1);
        low = {1'b0, addr & mask} + {31'h0, step};
        overflow = (size != 5'h00) && (low > {1'b0, mask});
        if (size == 5'h00) begin
            nextAddr = addr + {30'h0, step};
        end else begin
            nextAddr = (addr & ~mask) | (low[31:0] & mask);
        end
    end
endmodule // repeat_area_addr

// ==== rtl/dma_block_count_repeat_area.sv ====
// block counter and repeat-area control of one external-bus dma channel
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dma_map.svh"
module dma_block_count_repeat_area import dma_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic unitDone,
    output logic [31:0] srcAddr,
    output logic [31:0] dstAddr,
    output logic channelActive,
    output logic blockDone,
    output logic irq
);
    chanState_t state, next_state;
    logic [31:0] next_srcAddr, next_dstAddr, next_readdata;
    logic [15:0] xferCount, next_xferCount;
    logic [7:0] blockSize, next_blockSize;
    logic [8:0] unitsLeft, next_unitsLeft;
    logic [4:0] srcSize, next_srcSize, dstSize, next_dstSize;
    logic srcIrqEn, next_srcIrqEn, dstIrqEn, next_dstIrqEn;
    logic irqEnable, next_irqEnable, overflowFlag, next_overflowFlag;
    logic wordMode, next_wordMode;
    logic [2:0] status, next_status, intEnable, next_intEnable;
    logic next_channelActive, next_blockDone, next_irq, next_waitrequest;
    logic [31:0] srcStep, dstStep, beMask;
    logic srcOvf, dstOvf, accept, busWrite, running, blockEnd;
    logic [1:0] step;

    assign step = wordMode ? 2'h2 : 2'h1;
    assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};
    // a request is taken only in the cycle waitrequest is low
    assign accept = (read || write) && !waitrequest;
    assign busWrite = accept && write;
    assign running = (state == CH_RUN);
    assign blockEnd = running && unitDone && (unitsLeft == 9'h001);

    repeat_area_addr srcArea (
        .addr(srcAddr),
        .size(srcSize),
        .step(step),
        .nextAddr(srcStep),
        .overflow(srcOvf)
    );

    repeat_area_addr dstArea (
        .addr(dstAddr),
        .size(dstSize),
        .step(step),
        .nextAddr(dstStep),
        .overflow(dstOvf)
    );

    // bus answer: one wait cycle, then readdata with waitrequest low
    always_comb begin
        next_waitrequest = 1'b1;
        next_readdata = readdata;
        if ((read || write) && waitrequest) begin
            next_waitrequest = 1'b0;
            next_readdata = 32'h0;
            if (address == `OFF_SRC_ADDR) begin
                next_readdata = srcAddr;
            end else if (address == `OFF_DST_ADDR) begin
                next_readdata = dstAddr;
            end else if (address == `OFF_COUNT) begin
                next_readdata = {8'h0, blockSize, xferCount};
            end else if (address == `OFF_MODE) begin
                next_readdata = {26'h0, state, wordMode, overflowFlag,
                                 irqEnable, channelActive};
            end else if (address == `OFF_ADDR_CTRL) begin
                next_readdata = {14'h0, dstIrqEn, srcIrqEn, 3'h0, dstSize,
                                 3'h0, srcSize};
            end else if (address == `OFF_STATUS) begin
                next_readdata = {29'h0, status};
            end else if (address == `OFF_INT_EN) begin
                next_readdata = {29'h0, intEnable};
            end
        end
    end

    always_comb begin
        next_state = state;
        next_srcAddr = srcAddr;
        next_dstAddr = dstAddr;
        next_xferCount = xferCount;
        next_blockSize = blockSize;
        next_unitsLeft = unitsLeft;
        next_srcSize = srcSize;
        next_dstSize = dstSize;
        next_srcIrqEn = srcIrqEn;
        next_dstIrqEn = dstIrqEn;
        next_irqEnable = irqEnable;
        next_overflowFlag = overflowFlag;
        next_wordMode = wordMode;
        next_status = status;
        next_intEnable = intEnable;
        next_blockDone = 1'b0;
        if (busWrite) begin
            if (address == `OFF_SRC_ADDR) begin
                next_srcAddr = (srcAddr & ~beMask) | (writedata & beMask);
            end else if (address == `OFF_DST_ADDR) begin
                next_dstAddr = (dstAddr & ~beMask) | (writedata & beMask);
            end else if (address == `OFF_COUNT) begin
                if (byteenable[0]) begin
                    next_xferCount[7:0] = writedata[7:0];
                end
                if (byteenable[1]) begin
                    next_xferCount[15:8] = writedata[15:8];
                end
                if (byteenable[2]) begin
                    next_blockSize = writedata[23:16];
                    next_unitsLeft = {writedata[23:16] == 8'h00, writedata[23:16]};
                end
            end else if (address == `OFF_MODE && byteenable[0]) begin
                next_wordMode = writedata[`MODE_WORD];
                next_irqEnable = writedata[`MODE_IRQ_EN];
                // flag may only be cleared by software
                if (!writedata[`MODE_FLAG]) begin
                    next_overflowFlag = 1'b0;
                end
                next_state = writedata[`MODE_ACTIVE] ? CH_RUN : CH_IDLE;
            end else if (address == `OFF_ADDR_CTRL) begin
                if (byteenable[0]) begin
                    next_srcSize = writedata[`ACTRL_SRC_LSB +: 5];
                end
                if (byteenable[1]) begin
                    next_dstSize = writedata[`ACTRL_DST_LSB +: 5];
                end
                if (byteenable[2]) begin
                    next_srcIrqEn = writedata[`ACTRL_SRC_IE];
                    next_dstIrqEn = writedata[`ACTRL_DST_IE];
                end
            end else if (address == `OFF_INT_EN && byteenable[0]) begin
                next_intEnable = writedata[2:0];
            end else if (address == `OFF_INT_CLR && byteenable[0]) begin
                next_status = status & ~writedata[2:0];
            end
        end
        // unit progress comes after the bus so a hardware event wins
        if (running && unitDone) begin
            next_srcAddr = srcStep;
            next_dstAddr = dstStep;
            next_unitsLeft = unitsLeft - 9'h001;
            if (blockEnd) begin
                next_unitsLeft = {blockSize == 8'h00, blockSize};
                next_blockDone = 1'b1;
                if (xferCount != 16'h0000) begin
                    next_xferCount = xferCount - 16'h0001;
                    if (xferCount == 16'h0001) begin
                        next_state = CH_IDLE;
                        next_status[`EV_END] = 1'b1;
                    end
                end
            end
            // an overflow stop wins over the end of the last block
            // source overflow stop
            if (srcOvf && srcIrqEn) begin
                next_overflowFlag = 1'b1;
                next_state = CH_HALT;
                next_status[`EV_SRC_OVF] = 1'b1;
            end
            if (dstOvf && dstIrqEn) begin
                next_overflowFlag = 1'b1;
                next_state = CH_HALT;
                next_status[`EV_DST_OVF] = 1'b1;
            end
        end
        next_channelActive = (next_state == CH_RUN);
        next_irq = (next_overflowFlag && next_irqEnable) || |(next_status & next_intEnable);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= CH_IDLE;
            srcAddr <= `RST_ADDR;
            dstAddr <= `RST_ADDR;
            xferCount <= `RST_COUNT;
            blockSize <= `RST_BLKSZ;
            unitsLeft <= 9'h100;
            srcSize <= `RST_SIZE;
            dstSize <= `RST_SIZE;
            srcIrqEn <= 1'b0;
            dstIrqEn <= 1'b0;
            irqEnable <= 1'b0;
            overflowFlag <= 1'b0;
            wordMode <= 1'b0;
            status <= 3'h0;
            intEnable <= 3'h0;
            channelActive <= 1'b0;
            blockDone <= 1'b0;
            irq <= 1'b0;
            readdata <= 32'h0;
            waitrequest <= 1'b1;
        end else begin
            state <= next_state;
            srcAddr <= next_srcAddr;
            dstAddr <= next_dstAddr;
            xferCount <= next_xferCount;
            blockSize <= next_blockSize;
            unitsLeft <= next_unitsLeft;
            srcSize <= next_srcSize;
            dstSize <= next_dstSize;
            srcIrqEn <= next_srcIrqEn;
            dstIrqEn <= next_dstIrqEn;
            irqEnable <= next_irqEnable;
            overflowFlag <= next_overflowFlag;
            wordMode <= next_wordMode;
            status <= next_status;
            intEnable <= next_intEnable;
            channelActive <= next_channelActive;
            blockDone <= next_blockDone;
            irq <= next_irq;
            readdata <= next_readdata;
            waitrequest <= next_waitrequest;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_last_block: assert property (
        blockEnd && xferCount == 16'h0001 |=> !channelActive && status[`EV_END] && xferCount == 16'h0)
        else $error("last block did not end transfer");
    chk_zero_count: assert property (
        blockEnd && xferCount == 16'h0 && !srcOvf && !dstOvf && !busWrite && !status[`EV_END]
        |=> channelActive && xferCount == 16'h0 && !status[`EV_END])
        else $error("zero count ended transfer");
    chk_max_count: assert property (
        blockEnd && xferCount == 16'hffff |=> xferCount == 16'hfffe)
        else $error("all-ones count mishandled");
    chk_count_down: assert property (
        blockEnd && xferCount > 16'h0001 |=> xferCount == $past(xferCount) - 16'h0001)
        else $error("count did not decrement");
    chk_size_indep: assert property (
        busWrite && address == `OFF_ADDR_CTRL && byteenable == 4'h2
        |=> dstSize == $past(writedata[12:8]) && srcSize == $past(srcSize))
        else $error("repeat sizes not independent");
    chk_src_halt: assert property (
        running && unitDone && srcOvf && srcIrqEn |=> (overflowFlag && !channelActive) [*2])
        else $error("source overflow did not halt");
    chk_irq_req: assert property (
        overflowFlag && irqEnable |-> irq)
        else $error("overflow interrupt missing");
    chk_dst_halt: assert property (
        running && unitDone && dstOvf && dstIrqEn |=> overflowFlag && state == CH_HALT)
        else $error("destination overflow did not halt");
    chk_resume: assert property (
        busWrite && address == `OFF_MODE && byteenable[0] && writedata[0] && overflowFlag
        && !(running && unitDone) |=> channelActive && $stable(srcAddr) && $stable(xferCount))
        else $error("resume lost position");
    chk_block_size: assert property (
        blockEnd |=> unitsLeft == {$past(blockSize) == 8'h00, $past(blockSize)})
        else $error("block size reload wrong");
    chk_wrap_run: assert property (
        running && unitDone && srcOvf && !srcIrqEn && !(dstOvf && dstIrqEn)
        && !(blockEnd && xferCount == 16'h0001) && !busWrite
        |=> channelActive && srcAddr <= $past(srcAddr))
        else $error("wrap stopped transfer");
    chk_idle_units: assert property (
        !running && unitDone && !busWrite |=> $stable(srcAddr) && $stable(dstAddr))
        else $error("stopped channel moved an address");
    // block pulse only at block end
    chk_block_pulse: assert property (
        blockDone |-> $past(blockEnd))
        else $error("block pulse without block end");

    // main scenarios reached by the bench
    cov_end: cover property (blockEnd && xferCount == 16'h0001);
    cov_halt: cover property (running && unitDone && srcOvf && srcIrqEn);
    cov_resume: cover property (state == CH_HALT ##[1:50] state == CH_RUN);
    cov_dst_halt: cover property (running && unitDone && dstOvf && dstIrqEn);
    cov_wrap: cover property (running && unitDone && srcOvf && !srcIrqEn);
endmodule // dma_block_count_repeat_area

// ==== dv/unit_engine_model.sv ====
// behavioural bus engine that reports moved units to the channel
`timescale 1ns/1ps
module unit_engine_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic channelActive,
    input wire logic enable,
    input wire logic [3:0] gap,
    output logic unitDone
);
    logic [3:0] idleCnt;

    // a pulse may still be in flight when the channel stops; the channel must ignore it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unitDone <= 1'b0;
            idleCnt <= 4'h0;
        end else if (enable && channelActive && idleCnt >= gap) begin
            unitDone <= 1'b1;
            idleCnt <= 4'h0;
        end else begin
            unitDone <= 1'b0;
            if (idleCnt < gap) begin
                idleCnt <= idleCnt + 4'h1;
            end
        end
    end
endmodule // unit_engine_model

// ==== dv/dma_block_count_repeat_area_tb.sv ====
// self-checking bench for the block counter and repeat-area channel
`timescale 1ns/1ps
`include "dma_map.svh"
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errCount++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module dma_block_count_repeat_area_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata, srcAddr, dstAddr, q;
    logic waitrequest, unitDone, channelActive, blockDone, irq;
    logic engOn = 1'b0;
    logic [3:0] engGap = 4'h0;
    int errCount = 0;
    int nCompared = 0;
    int blkCnt = 0;
    int b;

    always #5 clk = ~clk;
    // counted on the falling edge so a check right after an edge sees the settled total
    always @(negedge clk) if (blockDone === 1'b1) blkCnt <= blkCnt + 1;

    dma_block_count_repeat_area uut (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .unitDone(unitDone),
        .srcAddr(srcAddr), .dstAddr(dstAddr), .channelActive(channelActive),
        .blockDone(blockDone), .irq(irq));
    unit_engine_model engine (.clk(clk), .rst_n(rst_n), .channelActive(channelActive),
        .enable(engOn), .gap(engGap), .unitDone(unitDone));

    // extra edges at the end let registered outputs such as irq settle
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20) `CHK("waitrequest", 1'b0, waitrequest)
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic waitIdle();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (channelActive !== 1'b0 && n < 2000);
        if (n >= 2000) `CHK("channel stop", 1'b0, channelActive)
    endtask
    task automatic start(input logic [31:0] s, d, c, ac, md);
        wr(`OFF_SRC_ADDR, s);
        wr(`OFF_DST_ADDR, d);
        wr(`OFF_COUNT, c);
        wr(`OFF_ADDR_CTRL, ac);
        wr(`OFF_MODE, md);
    endtask

    task automatic t_reset();
        for (int a = 0; a <= 'h18; a += 4) begin
            rd(8'(a));
            `CHK("reset value", 32'h0, q)
        end
        rd(8'h40);
        `CHK("unmapped", 32'h0, q)
        wr(`OFF_COUNT, 32'h0005_0000);
        bus(1'b1, `OFF_COUNT, 32'h00ab_ffff, 4'h3);
        rd(`OFF_COUNT);
        `CHK("count all ones", 32'h0005_ffff, q)
        bus(1'b1, `OFF_ADDR_CTRL, 32'h0000_1f1f, 4'h2);
        rd(`OFF_ADDR_CTRL);
        `CHK("dst size only", 32'h0000_1f00, q)
        $display("test reset done");
    endtask

    task automatic t_count();
        b = blkCnt;
        engGap <= 4'h3;
        engOn <= 1'b1;
        wr(`OFF_INT_EN, 32'h4);
        start(32'h100, 32'h200, 32'h0002_0003, 32'h0, 32'h1);
        repeat (200) if (blkCnt == b) @(posedge clk);
        engOn <= 1'b0;
        rd(`OFF_COUNT);
        `CHK("remaining", 32'h0002_0002, q)
        engOn <= 1'b1;
        waitIdle();
        `CHK("blocks", 3, blkCnt - b)
        `CHK("src end", 32'h106, srcAddr)
        `CHK("dst end", 32'h206, dstAddr)
        rd(`OFF_STATUS);
        `CHK("end status", 32'h4, q)
        `CHK("irq end", 1'b1, irq)
        wr(`OFF_INT_EN, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        wr(`OFF_INT_EN, 32'h4);
        wr(`OFF_INT_CLR, 32'h4);
        `CHK("irq cleared", 1'b0, irq)
        $display("test count done");
    endtask

    task automatic t_zero();
        engGap <= 4'h0;
        start(32'h400, 32'h500, 32'h0001_0000, 32'h0, 32'h1);
        repeat (300) @(posedge clk);
        `CHK("zero runs", 1'b1, channelActive)
        rd(`OFF_STATUS);
        `CHK("zero no end", 32'h0, q)
        wr(`OFF_MODE, 32'h0);
        rd(`OFF_COUNT);
        `CHK("zero count", 32'h0001_0000, q)
        // one-unit blocks: remaining count is all ones less the blocks seen
        b = blkCnt;
        start(32'h400, 32'h500, 32'h0001_ffff, 32'h0, 32'h1);
        repeat (20) @(posedge clk);
        wr(`OFF_MODE, 32'h0);
        rd(`OFF_COUNT);
        `CHK("max count", 16'hffff - 16'(blkCnt - b), q[15:0])
        b = blkCnt;
        start(32'h1000, 32'h2000, 32'h0000_0001, 32'h0, 32'h1);
        waitIdle();
        `CHK("size 256", 32'h1100, srcAddr)
        `CHK("one block", 1, blkCnt - b)
        wr(`OFF_INT_CLR, 32'h7);
        $display("test zero and size done");
    endtask

    task automatic t_srcOvf();
        start(32'h10c, 32'h200, 32'h0001_0000, 32'h0001_0004, 32'h3);
        waitIdle();
        `CHK("src wrap", 32'h100, srcAddr)
        `CHK("dst plain", 32'h204, dstAddr)
        rd(`OFF_MODE);
        `CHK("mode halted", 32'h26, q)
        `CHK("irq flag", 1'b1, irq)
        wr(`OFF_MODE, 32'h3);
        `CHK("irq resume", 1'b0, irq)
        `CHK("running", 1'b1, channelActive)
        waitIdle();
        `CHK("src again", 32'h100, srcAddr)
        `CHK("dst onward", 32'h214, dstAddr)
        wr(`OFF_MODE, 32'h0);
        `CHK("irq off", 1'b0, irq)
        rd(`OFF_STATUS);
        `CHK("src status", 32'h1, q)
        wr(`OFF_INT_CLR, 32'h7);
        $display("test source overflow done");
    endtask

    task automatic t_dstOvf();
        wr(`OFF_INT_EN, 32'h2);
        start(32'h300, 32'h206, 32'h0001_0000, 32'h0002_0300, 32'h1);
        waitIdle();
        `CHK("dst wrap", 32'h200, dstAddr)
        `CHK("src plain", 32'h302, srcAddr)
        rd(`OFF_STATUS);
        `CHK("dst status", 32'h2, q)
        `CHK("irq dst", 1'b1, irq)
        wr(`OFF_INT_CLR, 32'h2);
        `CHK("irq dst clr", 1'b0, irq)
        wr(`OFF_MODE, 32'h0);
        start(32'h302, 32'h600, 32'h0004_0001, 32'h2, 32'h1);
        waitIdle();
        `CHK("wrap no halt", 32'h302, srcAddr)
        `CHK("dst wrap run", 32'h604, dstAddr)
        rd(`OFF_STATUS);
        `CHK("wrap end", 32'h4, q)
        $display("test destination overflow done");
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_count();
        t_zero();
        t_srcOvf();
        t_dstOvf();
        summarize();
    end

    // the whole sequence needs about a thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        errCount++;
        $display("unexpected run length: expected end seen timeout");
        summarize();
    end
endmodule // dma_block_count_repeat_area_tb
